// File: common/apdu_pkg.sv
package apdu_pkg;

  localparam int BYTE_W = 8;
  localparam int SW_W = 16;
  localparam int INF_MAX_DEF = 32;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int FETCH_LEN = 5;

  // instruction codes
  localparam logic [7:0] INS_FETCH = 8'h12;
  localparam logic [7:0] INS_TERM_RESULT = 8'h14;
  localparam logic [7:0] INS_DATA_WRAP = 8'hc2;
  // class byte of generated retrieval commands; value is arbitrary
  localparam logic [7:0] CLA_DEF = 8'h80;
  localparam logic [7:0] P_ZERO = 8'h00;

  // status bytes
  localparam logic [7:0] SW1_NORMAL = 8'h61;
  localparam logic [7:0] SW1_WARN_A = 8'h62;
  localparam logic [7:0] SW1_WARN_B = 8'h63;
  localparam logic [3:0] SW1_APP_NIB = 4'h9;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] SW1_PENDING = 8'h91;
  localparam logic [7:0] SW1_TK_BUSY = 8'h93;
  localparam logic [7:0] SW2_TK_BUSY = 8'h00;

  typedef enum logic [3:0] {
    C_CMD = 4'b0001,
    C_WAIT = 4'b0010,
    C_DATA = 4'b0100,
    C_SW = 4'b1000
  } card_state_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_SEND = 4'b0010,
    T_FETCH = 4'b0100,
    T_RECV = 4'b1000
  } term_state_t;

  function automatic logic data_allowed(input logic [7:0] sw1);
    return (sw1 == SW1_NORMAL) || (sw1 == SW1_WARN_A) || (sw1 == SW1_WARN_B) || (sw1[7:4] == SW1_APP_NIB);
  endfunction

endpackage

// File: common/apdu_link_if.sv
`timescale 1ns/100ps
interface apdu_link_if (
  input wire logic clk,
  input wire logic reset_n
);
  // terminal to card block bytes
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic cmd_chain;
  logic cmd_ready;
  // card to terminal block bytes
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic rsp_chain;
  logic rsp_ready;

  modport term (
    input clk, reset_n, cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_chain,
    output cmd_valid, cmd_data, cmd_last, cmd_chain, rsp_ready
  );

  modport card (
    input clk, reset_n, cmd_valid, cmd_data, cmd_last, cmd_chain, rsp_ready,
    output rsp_valid, rsp_data, rsp_last, rsp_chain, cmd_ready
  );
endinterface

// File: src/apdu_card_end.sv
`timescale 1ns/100ps
module apdu_card_end #(
  parameter int INF_MAX = apdu_pkg::INF_MAX_DEF
) (
  apdu_link_if.card link,
  output logic cmd_out_valid,
  output logic [7:0] cmd_out_data,
  output logic cmd_out_first,
  output logic cmd_out_last,
  input wire logic cmd_out_ready,
  input wire logic sw_in_valid,
  input wire logic [15:0] sw_in,
  input wire logic has_data,
  output logic sw_ready,
  input wire logic rd_in_valid,
  input wire logic [7:0] rd_in_data,
  input wire logic rd_in_last,
  output logic rd_in_ready,
  input wire logic toolkit_busy,
  input wire logic proactive_pending,
  input wire logic [7:0] proactive_len
);
  wire clk = link.clk;
  wire reset_n = link.reset_n;

  apdu_pkg::card_state_t state_r;
  logic [1:0] idx_r;
  logic [7:0] ins_r;
  logic [15:0] sw_r;
  logic send_r;
  logic sw_idx_r;
  logic [7:0] blk_r;
  logic o_valid_r;
  logic [7:0] o_data_r;
  logic o_last_r;
  logic o_chain_r;
  logic can_load;
  logic ld;
  logic [7:0] ld_data;
  logic ld_end;
  logic cmd_take;
  logic cmd_end;
  logic [15:0] sw_eff;
  logic send_eff;

  assign can_load = !o_valid_r || link.rsp_ready;
  assign cmd_take = (state_r == apdu_pkg::C_CMD) && link.cmd_valid && cmd_out_ready;
  // chained blocks of one command are joined into one message
  assign cmd_end = link.cmd_last && !link.cmd_chain;
  assign link.cmd_ready = (state_r == apdu_pkg::C_CMD) && cmd_out_ready;
  assign cmd_out_valid = (state_r == apdu_pkg::C_CMD) && link.cmd_valid;
  assign cmd_out_data = link.cmd_data;
  assign cmd_out_first = (idx_r == 2'd0);
  assign cmd_out_last = cmd_end;
  assign sw_ready = (state_r == apdu_pkg::C_WAIT);

  always_comb begin
    sw_eff = sw_in;
    send_eff = has_data && apdu_pkg::data_allowed(sw_in[15:8]);
    if (ins_r == apdu_pkg::INS_DATA_WRAP && toolkit_busy) begin
      sw_eff = {apdu_pkg::SW1_TK_BUSY, apdu_pkg::SW2_TK_BUSY};
      send_eff = 1'b0;
    end else if (sw_in == {apdu_pkg::SW1_OK, apdu_pkg::SW2_OK} && proactive_pending) begin
      sw_eff = {apdu_pkg::SW1_PENDING, proactive_len};
    end
  end

  // data the card may not return is drained and discarded
  assign rd_in_ready = (state_r == apdu_pkg::C_DATA) && (can_load || !send_r);

  always_comb begin
    ld = 1'b0;
    ld_data = rd_in_data;
    ld_end = 1'b0;
    if (state_r == apdu_pkg::C_DATA) begin
      ld = send_r && rd_in_valid && can_load;
    end else if (state_r == apdu_pkg::C_SW) begin
      ld = can_load;
      ld_data = sw_idx_r ? sw_r[7:0] : sw_r[15:8];
      ld_end = sw_idx_r;
    end
  end

  // one response per command, exchange closed by the status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= apdu_pkg::C_CMD;
    end else begin
      unique case (state_r)
        apdu_pkg::C_CMD: if (cmd_take && cmd_end) state_r <= apdu_pkg::C_WAIT;
        apdu_pkg::C_WAIT: if (sw_in_valid) state_r <= has_data ? apdu_pkg::C_DATA : apdu_pkg::C_SW;
        apdu_pkg::C_DATA: if (rd_in_valid && rd_in_ready && rd_in_last) state_r <= apdu_pkg::C_SW;
        apdu_pkg::C_SW: if (ld && ld_end) state_r <= apdu_pkg::C_CMD;
        default: state_r <= apdu_pkg::C_CMD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idx_r <= 2'd0;
      ins_r <= 8'h00;
    end else if (cmd_take) begin
      if (idx_r == 2'd1) ins_r <= link.cmd_data;
      idx_r <= cmd_end ? 2'd0 : (idx_r == 2'd3 ? idx_r : idx_r + 2'd1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_r <= 16'h0000;
      send_r <= 1'b0;
      sw_idx_r <= 1'b0;
    end else begin
      if (state_r == apdu_pkg::C_WAIT && sw_in_valid) begin
        sw_r <= sw_eff;
        send_r <= send_eff;
        sw_idx_r <= 1'b0;
      end else if (ld && state_r == apdu_pkg::C_SW) begin
        sw_idx_r <= 1'b1;
      end
    end
  end

  // long responses go out as chained blocks
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      o_valid_r <= 1'b0;
      o_data_r <= 8'h00;
      o_last_r <= 1'b0;
      o_chain_r <= 1'b0;
      blk_r <= 8'h00;
    end else if (can_load) begin
      o_valid_r <= ld;
      if (ld) begin
        o_data_r <= ld_data;
        o_last_r <= ld_end || (blk_r == 8'(INF_MAX - 1));
        o_chain_r <= !ld_end;
        blk_r <= (ld_end || blk_r == 8'(INF_MAX - 1)) ? 8'h00 : blk_r + 8'h01;
      end
    end
  end

  assign link.rsp_valid = o_valid_r;
  assign link.rsp_data = o_data_r;
  assign link.rsp_last = o_last_r;
  assign link.rsp_chain = o_chain_r;

endmodule

// File: src/apdu_term_end.sv
`timescale 1ns/100ps
module apdu_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = apdu_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module apdu_term_end #(
  parameter int INF_MAX = apdu_pkg::INF_MAX_DEF,
  parameter int FIFO_DEPTH = apdu_pkg::FIFO_DEPTH_DEF,
  parameter logic [7:0] FETCH_CLA = apdu_pkg::CLA_DEF
) (
  apdu_link_if.term link,
  input wire logic app_cmd_valid,
  input wire logic [7:0] app_cmd_data,
  input wire logic app_cmd_last,
  output logic app_cmd_ready,
  output logic app_rsp_valid,
  output logic [7:0] app_rsp_data,
  output logic app_rsp_last,
  output logic app_rsp_fetched,
  output logic [15:0] app_sw,
  output logic app_done,
  output logic ack_ok,
  output logic ack_err,
  output logic busy
);
  wire clk = link.clk;
  wire reset_n = link.reset_n;

  apdu_pkg::term_state_t state_r;
  logic f_valid;
  logic [8:0] f_data;
  logic f_ready;
  logic [2:0] fidx_r;
  logic [1:0] idx_r;
  logic wrap_r;
  logic fetch_r;
  logic fetch_due_r;
  logic [7:0] le_r;
  logic [15:0] sw_r;
  logic [7:0] blk_r;
  logic o_valid_r;
  logic [7:0] o_data_r;
  logic o_last_r;
  logic o_chain_r;
  logic can_load;
  logic ld;
  logic [7:0] ld_data;
  logic ld_end;
  logic rsp_take;
  logic rsp_end;
  logic [15:0] sw_new;
  logic [7:0] fetch_byte;

  // command staging buffer; full fifo stalls the application
  apdu_byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) apdu_byte_fifo_i (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(app_cmd_valid),
    .in_data({app_cmd_last, app_cmd_data}),
    .in_ready(app_cmd_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  assign can_load = !o_valid_r || link.cmd_ready;
  assign f_ready = (state_r == apdu_pkg::T_SEND) && can_load;

  always_comb begin
    unique case (fidx_r)
      3'd0: fetch_byte = FETCH_CLA;
      3'd1: fetch_byte = apdu_pkg::INS_FETCH;
      3'd2: fetch_byte = apdu_pkg::P_ZERO;
      3'd3: fetch_byte = apdu_pkg::P_ZERO;
      default: fetch_byte = le_r;
    endcase
  end

  always_comb begin
    ld = 1'b0;
    ld_data = f_data[7:0];
    ld_end = f_data[8];
    if (state_r == apdu_pkg::T_SEND) begin
      ld = f_valid && can_load;
    end else if (state_r == apdu_pkg::T_FETCH) begin
      ld = can_load;
      ld_data = fetch_byte;
      ld_end = (fidx_r == 3'(apdu_pkg::FETCH_LEN - 1));
    end
  end

  assign link.rsp_ready = (state_r == apdu_pkg::T_RECV);
  assign rsp_take = link.rsp_valid && link.rsp_ready;
  assign rsp_end = link.rsp_last && !link.rsp_chain;
  assign sw_new = {sw_r[7:0], link.rsp_data};
  assign busy = (state_r != apdu_pkg::T_IDLE);

  // retrieval outranks queued commands so the pending one is fetched first
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= apdu_pkg::T_IDLE;
    end else begin
      unique case (state_r)
        apdu_pkg::T_IDLE: begin
          if (fetch_due_r) state_r <= apdu_pkg::T_FETCH;
          else if (f_valid) state_r <= apdu_pkg::T_SEND;
        end
        apdu_pkg::T_SEND: if (ld && ld_end) state_r <= apdu_pkg::T_RECV;
        apdu_pkg::T_FETCH: if (ld && ld_end) state_r <= apdu_pkg::T_RECV;
        apdu_pkg::T_RECV: if (rsp_take && rsp_end) state_r <= apdu_pkg::T_IDLE;
        default: state_r <= apdu_pkg::T_IDLE;
      endcase
    end
  end

  // note the instruction byte to spot data-wrap exchanges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idx_r <= 2'd0;
      wrap_r <= 1'b0;
      fetch_r <= 1'b0;
      fidx_r <= 3'd0;
    end else if (ld) begin
      if (idx_r == 2'd1) begin
        wrap_r <= (ld_data == apdu_pkg::INS_DATA_WRAP);
        fetch_r <= (state_r == apdu_pkg::T_FETCH);
      end
      idx_r <= ld_end ? 2'd0 : (idx_r == 2'd3 ? idx_r : idx_r + 2'd1);
      fidx_r <= (state_r == apdu_pkg::T_FETCH && !ld_end) ? fidx_r + 3'd1 : 3'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      o_valid_r <= 1'b0;
      o_data_r <= 8'h00;
      o_last_r <= 1'b0;
      o_chain_r <= 1'b0;
      blk_r <= 8'h00;
    end else if (can_load) begin
      o_valid_r <= ld;
      if (ld) begin
        o_data_r <= ld_data;
        o_last_r <= ld_end || (blk_r == 8'(INF_MAX - 1));
        o_chain_r <= !ld_end;
        blk_r <= (ld_end || blk_r == 8'(INF_MAX - 1)) ? 8'h00 : blk_r + 8'h01;
      end
    end
  end

  assign link.cmd_valid = o_valid_r;
  assign link.cmd_data = o_data_r;
  assign link.cmd_last = o_last_r;
  assign link.cmd_chain = o_chain_r;

  // response bytes go up unchanged, status is the final two
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      app_rsp_valid <= 1'b0;
      app_rsp_data <= 8'h00;
      app_rsp_last <= 1'b0;
      sw_r <= 16'h0000;
    end else begin
      app_rsp_valid <= rsp_take;
      if (rsp_take) begin
        app_rsp_data <= link.rsp_data;
        app_rsp_last <= rsp_end;
        sw_r <= rsp_end ? 16'h0000 : sw_new;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      app_sw <= 16'h0000;
      app_done <= 1'b0;
      app_rsp_fetched <= 1'b0;
      ack_ok <= 1'b0;
      ack_err <= 1'b0;
      fetch_due_r <= 1'b0;
      le_r <= 8'h00;
    end else begin
      app_done <= rsp_take && rsp_end;
      ack_ok <= 1'b0;
      ack_err <= 1'b0;
      if (state_r == apdu_pkg::T_FETCH) fetch_due_r <= 1'b0;
      if (rsp_take && rsp_end) begin
        app_sw <= sw_new;
        app_rsp_fetched <= fetch_r;
        if (sw_new[15:8] == apdu_pkg::SW1_PENDING) begin
          fetch_due_r <= 1'b1;
          le_r <= sw_new[7:0];
        end
        if (wrap_r) begin
          ack_ok <= (sw_new == {apdu_pkg::SW1_OK, apdu_pkg::SW2_OK});
          ack_err <= (sw_new[15:8] == apdu_pkg::SW1_WARN_A) || (sw_new[15:8] == apdu_pkg::SW1_WARN_B);
        end
      end
    end
  end

endmodule

// File: bench/apdu_link_checker.sv
`timescale 1ns/100ps
module apdu_link_checker #(
  parameter int INF_MAX = apdu_pkg::INF_MAX_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_chain,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_chain,
  input wire logic rsp_ready
);
  logic [15:0] cmd_cnt_r;
  logic [15:0] rsp_cnt_r;
  logic [15:0] msg_cnt_r;
  logic [7:0] prev_r;
  logic open_r;
  wire cmd_tk = cmd_valid && cmd_ready;
  wire rsp_tk = rsp_valid && rsp_ready;
  wire rsp_end = rsp_tk && rsp_last && !rsp_chain;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) begin
    if (!reset_n || (cmd_tk && cmd_last)) begin
      cmd_cnt_r <= 16'h0000;
    end else if (cmd_tk) begin
      cmd_cnt_r <= cmd_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n || (rsp_tk && rsp_last)) begin
      rsp_cnt_r <= 16'h0000;
    end else if (rsp_tk) begin
      rsp_cnt_r <= rsp_cnt_r + 16'h0001;
    end
  end
  // bytes of the response message before the current one; prev_r then holds the first status byte
  always_ff @(posedge clk) begin
    if (!reset_n || rsp_end) begin
      msg_cnt_r <= 16'h0000;
    end else if (rsp_tk) begin
      msg_cnt_r <= msg_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rsp_tk) begin
      prev_r <= rsp_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n || rsp_end) begin
      open_r <= 1'b0;
    end else if (cmd_tk && cmd_last && !cmd_chain) begin
      open_r <= 1'b1;
    end
  end
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_data, cmd_last, cmd_chain}))
    else $error("command byte moved before taken");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable({rsp_data, rsp_last, rsp_chain}))
    else $error("response byte moved before taken");
  a_cmd_chain_end: assert property (cmd_valid && !cmd_chain |-> cmd_last)
    else $error("command chain dropped inside block");
  a_rsp_chain_end: assert property (rsp_valid && !rsp_chain |-> rsp_last)
    else $error("response chain dropped inside block");
  a_cmd_blk_len: assert property (cmd_tk && cmd_cnt_r == 16'(INF_MAX - 1) |-> cmd_last)
    else $error("command block too long");
  a_rsp_blk_len: assert property (rsp_tk && rsp_cnt_r == 16'(INF_MAX - 1) |-> rsp_last)
    else $error("response block too long");
  a_cmd_waits: assert property (open_r |-> !cmd_valid)
    else $error("command sent during response");
  a_rsp_paired: assert property (rsp_valid |-> open_r)
    else $error("response without command");
  a_data_status: assert property (rsp_end && msg_cnt_r > 16'h0001 |-> prev_r inside {8'h61, 8'h62, 8'h63}
    || prev_r[7:4] == 4'h9)
    else $error("data sent with other status");
endmodule

// File: bench/block_protocol_apdu_transport_bench.sv
`timescale 1ns/100ps
module block_protocol_apdu_transport_bench;
  localparam int IM = 8;
  typedef struct {
    logic [7:0] ins;
    int ncmd;
    logic [15:0] sw;
    int nd;
    logic tb;
    int efw;
    logic [15:0] esw;
    logic [1:0] eack;
  } row_t;
  row_t rows[12] = '{
    '{8'ha4, 4, 16'h9000, 0, 0, 0, 16'h9000, 2'b00},
    '{8'hb0, 5, 16'h9000, 3, 1, 3, 16'h9000, 2'b00},
    '{8'hd6, 9, 16'h6a82, 2, 0, 0, 16'h6a82, 2'b00},
    '{8'hb2, 5, 16'h6105, 2, 0, 2, 16'h6105, 2'b00},
    '{8'hb2, 5, 16'h9f10, 1, 0, 1, 16'h9f10, 2'b00},
    '{8'h88, 20, 16'h9000, 12, 0, 12, 16'h9000, 2'b00},
    '{8'h14, 7, 16'h9000, 0, 0, 0, 16'h9000, 2'b00},
    '{8'hc2, 8, 16'h9000, 2, 0, 2, 16'h9000, 2'b10},
    '{8'hc2, 8, 16'h6300, 2, 0, 2, 16'h6300, 2'b01},
    '{8'hc2, 8, 16'h6201, 1, 0, 1, 16'h6201, 2'b01},
    '{8'hc2, 8, 16'h9000, 2, 1, 0, 16'h9300, 2'b00},
    '{8'hc2, 8, 16'h6a80, 1, 0, 0, 16'h6a80, 2'b00}
  };
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic app_cmd_valid = 1'b0;
  logic [7:0] app_cmd_data = 8'h00;
  logic app_cmd_last = 1'b0;
  logic cmd_out_ready = 1'b1;
  logic sw_in_valid = 1'b0;
  logic [15:0] sw_in = 16'h0000;
  logic has_data = 1'b0;
  logic rd_in_valid = 1'b0;
  logic [7:0] rd_in_data = 8'h00;
  logic rd_in_last = 1'b0;
  logic toolkit_busy = 1'b0;
  logic proactive_pending = 1'b0;
  logic [7:0] proactive_len = 8'h00;
  logic app_cmd_ready, app_rsp_valid, app_rsp_fetched, app_done, ack_ok, ack_err, busy;
  logic cmd_out_valid, sw_ready, rd_in_ready, fet_seen, app_rsp_last, cmd_out_first, cmd_out_last;
  logic [7:0] app_rsp_data, cmd_out_data;
  logic [15:0] app_sw, sw_seen;
  logic [1:0] ack_seen;
  logic [7:0] cmd_q[$], exp_q[$], rsp_q[$];
  logic [15:0] plan_sw[$];
  int plan_nd[$];
  int failures = 0, cmp_count = 0, done_n = 0, cmd_chn = 0, rsp_chn = 0, cyc = 0, nd, c0, r0, d0;
  int fl_n = 0, ls_n = 0, rl_n = 0;
  always #50 clk = ~clk;
  apdu_link_if link (.clk(clk), .reset_n(reset_n));
  apdu_term_end #(.INF_MAX(IM)) apdu_term_end_i (.link(link), .app_cmd_valid(app_cmd_valid),
    .app_cmd_data(app_cmd_data), .app_cmd_last(app_cmd_last), .app_cmd_ready(app_cmd_ready),
    .app_rsp_valid(app_rsp_valid), .app_rsp_data(app_rsp_data), .app_rsp_last(app_rsp_last),
    .app_rsp_fetched(app_rsp_fetched),
    .app_sw(app_sw), .app_done(app_done), .ack_ok(ack_ok), .ack_err(ack_err), .busy(busy));
  apdu_card_end #(.INF_MAX(IM)) apdu_card_end_i (.link(link), .cmd_out_valid(cmd_out_valid),
    .cmd_out_data(cmd_out_data), .cmd_out_first(cmd_out_first), .cmd_out_last(cmd_out_last),
    .cmd_out_ready(cmd_out_ready),
    .sw_in_valid(sw_in_valid), .sw_in(sw_in), .has_data(has_data), .sw_ready(sw_ready), .rd_in_valid(rd_in_valid),
    .rd_in_data(rd_in_data), .rd_in_last(rd_in_last), .rd_in_ready(rd_in_ready), .toolkit_busy(toolkit_busy),
    .proactive_pending(proactive_pending), .proactive_len(proactive_len));
  apdu_link_checker #(.INF_MAX(IM)) apdu_link_checker_i (.clk(clk), .reset_n(reset_n),
    .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last), .cmd_chain(link.cmd_chain),
    .cmd_ready(link.cmd_ready), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last),
    .rsp_chain(link.rsp_chain), .rsp_ready(link.rsp_ready));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cmd_out_valid && cmd_out_ready) cmd_q.push_back(cmd_out_data);
    if (app_rsp_valid) rsp_q.push_back(app_rsp_data);
    if (cmd_out_valid && cmd_out_ready && cmd_out_first) fl_n++;
    if (cmd_out_valid && cmd_out_ready && cmd_out_last) ls_n++;
    if (app_rsp_valid && app_rsp_last) rl_n++;
    if (link.cmd_valid && link.cmd_ready && link.cmd_last && link.cmd_chain) cmd_chn++;
    if (link.rsp_valid && link.rsp_ready && link.rsp_last && link.rsp_chain) rsp_chn++;
    if (app_done) begin
      done_n++;
      sw_seen = app_sw;
      ack_seen = {ack_ok, ack_err};
      fet_seen = app_rsp_fetched;
    end
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  // card application: status first, then data bytes under handshake
  initial begin
    forever begin
      @(negedge clk);
      if (sw_ready === 1'b1 && plan_sw.size() > 0) begin
        sw_in = plan_sw.pop_front();
        nd = plan_nd.pop_front();
        has_data = nd > 0;
        sw_in_valid = 1'b1;
        @(negedge clk);
        sw_in_valid = 1'b0;
        for (int k = 0; k < nd; k++) begin
          rd_in_valid = 1'b1;
          rd_in_data = 8'h30 + 8'(k);
          rd_in_last = k == nd - 1;
          while (rd_in_ready !== 1'b1) @(negedge clk);
          @(negedge clk);
        end
        rd_in_valid = 1'b0;
      end
    end
  end
  task automatic send_cmd(input int n, input logic [7:0] ins);
    for (int i = 0; i < n; i++) begin
      app_cmd_data = (i == 1) ? ins : ((ins == apdu_pkg::INS_DATA_WRAP && i == n - 1) ? 8'h00 : 8'h40 + 8'(i));
      app_cmd_last = i == n - 1;
      app_cmd_valid = 1'b1;
      exp_q.push_back(app_cmd_data);
      while (app_cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    app_cmd_valid = 1'b0;
  endtask
  task automatic start_ex;
    d0 = done_n;
    c0 = cmd_chn;
    r0 = rsp_chn;
    rsp_q.delete();
    cmd_q.delete();
    exp_q.delete();
  endtask
  task automatic wait_done(input int n);
    for (int t = 0; t < 3000 && done_n < n; t++) @(negedge clk);
    check("done_count", 16'(n), 16'(done_n));
  endtask
  task automatic cmp_cmd;
    check("cmd_len", 16'(exp_q.size()), 16'(cmd_q.size()));
    foreach (exp_q[k]) check("cmd_byte", {8'h00, exp_q[k]}, {8'h00, cmd_q[k]});
  endtask
  task automatic run_row(input row_t r);
    logic [7:0] eb;
    start_ex();
    toolkit_busy = r.tb;
    plan_sw.push_back(r.sw);
    plan_nd.push_back(r.nd);
    send_cmd(r.ncmd, r.ins);
    wait_done(d0 + 1);
    check("app_sw", r.esw, sw_seen);
    check("acks", {14'h0000, r.eack}, {14'h0000, ack_seen});
    check("rsp_len", 16'(r.efw + 2), 16'(rsp_q.size()));
    for (int k = 0; k < r.efw + 2; k++) begin
      eb = k < r.efw ? 8'h30 + 8'(k) : (k == r.efw ? r.esw[15:8] : r.esw[7:0]);
      check("rsp_byte", {8'h00, eb}, {8'h00, rsp_q[k]});
    end
    check("cmd_chain", 16'((r.ncmd - 1) / IM), 16'(cmd_chn - c0));
    check("rsp_chain", 16'((r.efw + 1) / IM), 16'(rsp_chn - r0));
    cmp_cmd();
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("reset_outs", 16'h0008, {12'h000, app_cmd_ready, busy, sw_ready, app_done});
    foreach (rows[i]) run_row(rows[i]);
    start_ex();
    proactive_pending = 1'b1;
    proactive_len = 8'h03;
    plan_sw = '{16'h9000, 16'h9000};
    plan_nd = '{2, 3};
    send_cmd(6, 8'h88);
    wait_done(d0 + 1);
    proactive_pending = 1'b0;
    check("pend_sw", 16'h9103, sw_seen);
    check("pend_fetched", 16'h0000, {15'h0000, fet_seen});
    exp_q = {exp_q, apdu_pkg::CLA_DEF, apdu_pkg::INS_FETCH, apdu_pkg::P_ZERO, apdu_pkg::P_ZERO, 8'h03};
    wait_done(d0 + 2);
    check("fetch_sw", 16'h9000, sw_seen);
    check("fetched", 16'h0001, {15'h0000, fet_seen});
    check("fetch_rsp_len", 16'h0009, 16'(rsp_q.size()));
    cmp_cmd();
    // stalled far side: the buffer must refuse before the card takes anything
    start_ex();
    cmd_out_ready = 1'b0;
    plan_sw = '{16'h9000, 16'h6a82};
    plan_nd = '{0, 0};
    fork
      send_cmd(16, 8'hd6);
      begin
        repeat (40) @(negedge clk);
        check("fifo_full", 16'h0001, {14'h0000, app_cmd_ready, busy});
        cmd_out_ready = 1'b1;
      end
    join
    @(negedge clk);
    send_cmd(4, 8'ha4);
    wait_done(d0 + 2);
    check("last_sw", 16'h6a82, sw_seen);
    cmp_cmd();
    // second reset in mid-run, then one plain exchange to show recovery
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("reset_again", 16'h0008, {12'h000, app_cmd_ready, busy, sw_ready, app_done});
    run_row(rows[0]);
    // seventeen commands in all, generated retrieval included
    check("cmd_first_n", 16'h0011, 16'(fl_n));
    check("cmd_last_n", 16'h0011, 16'(ls_n));
    check("rsp_last_n", 16'h0011, 16'(rl_n));
    final_report();
  end
endmodule
